// *** pkg/gch_pkg.sv ***
package gch_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NCH = 17;
   localparam int NGPIO = 2;
   localparam int NSRC = 8;
   localparam int AW = 11;
   localparam int DW = 8;
   localparam int SER_CW = 5;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int RST_TIME_NS = 2000;
   // Longest time, so the cycle count rounds down
   localparam int RST_CYC = RST_TIME_NS / CLK_PERIOD_NS;
   localparam int RST_CW = 8;
   // Hold state takes one edge and the count starts at zero, so the last count is two short
   localparam logic [RST_CW-1:0] RST_LAST = RST_CW'(RST_CYC - 2);

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int CH_MODE_POS = 0;
   localparam int CH_DRV_POS = 1;
   localparam int GPIO_DIR_POS = 0;
   localparam int GPIO_LVL_POS = 2;
   localparam logic [3:0] GPIO_RST = 4'h0;
   localparam int GCFG_INT_POS = 2;
   localparam int INT_LVL_BIT = 0;
   localparam int INT_PP_BIT = 1;

   // ----------------------------------------
   // Serial frame layout
   // ----------------------------------------
   localparam logic [SER_CW-1:0] SER_HDR_LAST = 5'h0F;
   localparam logic [SER_CW-1:0] SER_DAT_LAST = 5'h17;
   localparam int SER_RW_POS = 15;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      GCH_RS_HOLD = 2'b00,
      GCH_RS_SEQ = 2'b01,
      GCH_RS_RUN = 2'b11
   } gch_rst_e;
endpackage

// *** tb/gch_host_model.sv ***
`timescale 1ns/1ns
module gch_host_model (
   // Clock
   input wire logic core_clk,
   // Host pins toward the device
   output logic cs_n,
   output logic host_pin_strobe,
   output logic host_serial_in,
   output logic addr_latch_strobe,
   output logic [gch_pkg::AW-1:0] host_addr_pin,
   output logic [gch_pkg::DW-1:0] host_data_in,
   // Device answers
   input wire logic host_ack,
   input wire logic [gch_pkg::DW-1:0] host_data_out,
   input wire logic host_serial_out,
   // Accesses that never saw an acknowledge
   output int hangs
);
   import gch_pkg::*;

   // ----------------------------------------
   // Idle bus: deselected, strobes high
   // ----------------------------------------
   initial begin
      cs_n = 1'b1;
      host_pin_strobe = 1'b1;
      host_serial_in = 1'b1;
      addr_latch_strobe = 1'b1;
      host_addr_pin = '0;
      host_data_in = '0;
      hangs = 0;
   end

   task automatic tk(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Strobe wiggles with the chip deselected
   task automatic stray();
      @(posedge core_clk);
      host_pin_strobe <= 1'b0;
      host_serial_in <= 1'b0;
      tk(3);
      host_pin_strobe <= 1'b1;
      host_serial_in <= 1'b1;
      tk(3);
   endtask

   // One parallel access; a fresh select fall each time, held until acknowledge
   task automatic par_access(input logic ds, mx, rd, input logic [AW-1:0] a,
                             input logic [DW-1:0] d, input int slow, output logic [DW-1:0] q);
      int i;
      @(posedge core_clk);
      cs_n <= 1'b0;
      // Low address byte is ignored on a muxed bus, so show it garbage
      host_addr_pin <= mx ? {a[10:8], ~a[7:0]} : a;
      host_data_in <= mx ? a[7:0] : (rd ? ~d : d);
      if (ds) begin
         host_serial_in <= rd;
      end
      tk(1 + slow);
      if (mx) begin
         addr_latch_strobe <= 1'b0;
         tk(1);
         host_data_in <= rd ? ~a[7:0] : d;
         tk(1);
      end
      if (ds || rd) begin
         host_pin_strobe <= 1'b0;
      end else begin
         host_serial_in <= 1'b0;
      end
      for (i = 0; i < 30 && host_ack !== 1'b1; i++) begin
         @(posedge core_clk);
      end
      if (i == 30) begin
         hangs++;
      end
      q = host_data_out;
      host_pin_strobe <= 1'b1;
      host_serial_in <= 1'b1;
      addr_latch_strobe <= 1'b1;
      cs_n <= 1'b1;
      host_data_in <= ~host_data_in;
      tk(1 + slow);
   endtask

   // Serial frame; shift clock stands high between frames, read data taken on its rise
   task automatic ser_access(input logic rd, input logic [AW-1:0] a, input logic [DW-1:0] d,
                             output logic [DW-1:0] q);
      logic [23:0] f;
      f = {rd, 4'h0, a, d};
      @(posedge core_clk);
      cs_n <= 1'b0;
      tk(2);
      for (int i = 23; i >= 0; i--) begin
         host_pin_strobe <= 1'b0;
         host_serial_in <= f[i];
         tk(2);
         if (i < DW) q[i] = host_serial_out;
         host_pin_strobe <= 1'b1;
         tk(2);
      end
      host_serial_in <= ~f[0];
      cs_n <= 1'b1;
      tk(2);
   endtask
endmodule

// *** tb/gch_top_tb.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %s expected %0h seen %0h", nm, (e), (g)); end end
module gch_top_tb;
   import gch_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   int err_total = 0;
   int comparisons = 0;
   logic line_drv_enable = 1'b1, hwse = 1'b1, hwpin = 1'b1, gpio_wr = 1'b0;
   logic ps_strap = 1'b1, style = 1'b1, muxs = 1'b0;
   logic [NCH-1:0][7:0] chcfg = '0;
   logic [3:0] gpio_wdata = 4'h0, gw;
   logic [1:0] gpio_in = 2'h0;
   logic [7:0] gcfg = 8'h00, pend = 8'h00, mask = 8'h00, host_rdata = 8'h00;
   logic cs_n, strobe, sin, ale, dev_ready, irq_out, irq_oe, host_ack, host_rd, host_wr;
   logic is_par, is_ds, is_mux, sout, data_oe;
   logic [AW-1:0] addr_pin, host_addr, ta;
   logic [DW-1:0] data_in, data_out, host_wdata, td, q;
   logic [NCH-1:0] line_drv_on, chan_e1_mode;
   logic [3:0] gpio_rdata;
   logic [1:0] gpio_out, gpio_oe;
   int hangs, wr_cnt = 0, rd_cnt = 0, n0, oe_cnt = 0, oe0;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   // Board pull holds a released interrupt line at its inactive level
   wire irq_pin = irq_oe ? irq_out : ~gcfg[GCFG_INT_POS+INT_LVL_BIT];

   always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

   gch_top DUT (.core_clk(core_clk), .nrst(nrst), .line_drv_enable(line_drv_enable),
      .hw_line_mode_select_enable(hwse), .hw_line_mode_pin(hwpin),
      .channel_config_reg(chcfg), .line_drv_on(line_drv_on), .chan_e1_mode(chan_e1_mode),
      .dev_ready(dev_ready), .gpio_wr(gpio_wr), .gpio_wdata(gpio_wdata),
      .gpio_rdata(gpio_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .global_config_reg(gcfg), .int_pending(pend), .int_mask(mask), .irq_out(irq_out),
      .irq_oe(irq_oe), .cs_n(cs_n), .ps_strap(ps_strap), .parallel_bus_style_strap(style),
      .bus_multiplex_strap(muxs), .host_pin_strobe(strobe), .host_serial_in(sin),
      .addr_latch_strobe(ale), .host_addr_pin(addr_pin), .host_data_in(data_in),
      .host_data_out(data_out), .host_data_oe(data_oe), .host_ack(host_ack),
      .host_serial_out(sout),
      .host_is_parallel(is_par), .host_is_ds_style(is_ds), .host_is_muxed(is_mux),
      .host_rd(host_rd), .host_wr(host_wr), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_rdata(host_rdata));

   gch_host_model host (.core_clk(core_clk), .cs_n(cs_n), .host_pin_strobe(strobe),
      .host_serial_in(sin), .addr_latch_strobe(ale), .host_addr_pin(addr_pin),
      .host_data_in(data_in), .host_ack(host_ack), .host_data_out(data_out),
      .host_serial_out(sout), .hangs(hangs));

   // ----------------------------------------
   // Register-side monitor and read data
   // ----------------------------------------
   always @(posedge core_clk) begin
      if (host_wr === 1'b1) begin
         wr_cnt++;
         wr_addr = host_addr;
         wr_data = host_wdata;
      end
      if (host_rd === 1'b1) begin
         rd_cnt++;
      end
      if (data_oe === 1'b1) oe_cnt++;
      host_rdata <= host_addr[7:0] ^ 8'h5A;
   end

   // ----------------------------------------
   // Expectations
   // ----------------------------------------
   function automatic logic [NCH-1:0] exp_mode(logic se, logic pin, logic [NCH-1:0][7:0] c);
      for (int i = 0; i < NCH; i++) exp_mode[i] = se ? ~pin : c[i][CH_MODE_POS];
   endfunction

   function automatic logic [NCH-1:0] exp_drv(logic en, logic [NCH-1:0][7:0] c);
      for (int i = 0; i < NCH; i++) exp_drv[i] = en & c[i][CH_DRV_POS];
   endfunction

   function automatic logic exp_irq(logic [7:0] g, logic [7:0] p, logic [7:0] m);
      return (|(p & ~m)) ? g[GCFG_INT_POS+INT_LVL_BIT] : ~g[GCFG_INT_POS+INT_LVL_BIT];
   endfunction

   task automatic tally_and_finish();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Reset with a strap set; straps are only latched during the sequence
   task automatic do_reset(input logic ps, st, mx);
      int n;
      @(posedge core_clk);
      nrst <= 1'b0;
      ps_strap <= ps;
      style <= st;
      muxs <= mx;
      repeat (20) @(posedge core_clk);
      #1;
      `CHK("gpio_oe", 2'b00, gpio_oe)
      `CHK("line_drv_on", {NCH{1'b0}}, line_drv_on)
      @(posedge core_clk);
      nrst <= 1'b1;
      for (n = 0; n < 300 && dev_ready !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      `CHK("ready_in_time", 1'b1, n <= RST_CYC)
      if (n == 300) tally_and_finish();
      `CHK("host_is_parallel", ps, is_par)
      if (ps) begin
         `CHK("host_is_ds_style", ~st, is_ds)
         `CHK("host_is_muxed", mx, is_mux)
      end
   endtask

   // Write then read back at the complement address, one slow, one prompt
   task automatic host_rw_check(input logic st, mx);
      ta = 11'($urandom);
      td = 8'($urandom);
      n0 = wr_cnt;
      oe0 = oe_cnt;
      host.stray();
      `CHK("stray_writes", n0, wr_cnt)
      host.par_access(~st, mx, 1'b0, ta, td, 2, q);
      `CHK("write_count", n0 + 1, wr_cnt)
      `CHK("write_addr", ta, wr_addr)
      `CHK("write_data", td, wr_data)
      `CHK("write_oe", oe0, oe_cnt)
      n0 = rd_cnt;
      host.par_access(~st, mx, 1'b1, ~ta, 8'h00, 0, q);
      `CHK("read_count", n0 + 1, rd_cnt)
      `CHK("read_data", (~ta[7:0]) ^ 8'h5A, q)
      `CHK("read_oe", 1'b1, oe_cnt > oe0)
      `CHK("access_hangs", 0, hangs)
      if (hangs != 0) tally_and_finish();
   endtask

   initial begin
      void'($urandom(32'h32587373));
      do_reset(1'b1, 1'b1, 1'b0);
      // Driver enable and mode source, every combination
      for (int k = 0; k < 8; k++) begin
         @(posedge core_clk);
         line_drv_enable <= k[0];
         hwse <= k[1];
         hwpin <= k[2];
         for (int c = 0; c < NCH; c++) chcfg[c] <= 8'($urandom);
         repeat (3) @(posedge core_clk);
         #1;
         `CHK("line_drv_on", exp_drv(k[0], chcfg), line_drv_on)
         `CHK("chan_e1_mode", exp_mode(k[1], k[2], chcfg), chan_e1_mode)
      end
      // GPIO: random settings, then the four corners, ending all outputs high
      for (int k = 0; k < 12; k++) begin
         @(posedge core_clk);
         gpio_wr <= 1'b1;
         gpio_wdata <= (k >= 8) ? 4'((k - 8) * 5) : 4'($urandom);
         gpio_in <= 2'($urandom);
         @(posedge core_clk);
         gpio_wr <= 1'b0;
         repeat (4) @(posedge core_clk);
         #1;
         gw = gpio_wdata;
         `CHK("gpio_oe", gw[1:0], gpio_oe)
         `CHK("gpio_out", gw[3:2] & gw[1:0], gpio_out & gw[1:0])
         `CHK("gpio_rdata", {(gw[3:2] & gw[1:0]) | (gpio_in & ~gw[1:0]), gw[1:0]}, gpio_rdata)
      end
      // Interrupt pin over all four configurations, idle, masked and live
      for (int k = 0; k < 16; k++) begin
         @(posedge core_clk);
         gcfg <= (8'($urandom) & 8'hF3) | {4'h0, 2'(k), 2'b00};
         pend <= (k < 4) ? 8'h00 : 8'($urandom);
         mask <= (k < 8) ? 8'hFF : ((k < 12) ? 8'h00 : 8'($urandom));
         repeat (3) @(posedge core_clk);
         #1;
         `CHK("irq_pin", exp_irq(gcfg, pend, mask), irq_pin)
         if (gcfg[GCFG_INT_POS+INT_PP_BIT]) `CHK("irq_oe", 1'b1, irq_oe)
      end
      // Parallel host styles; each reset also clears the GPIO outputs
      for (int s = 0; s < 4; s++) begin
         do_reset(1'b1, s[0], s[1]);
         host_rw_check(s[0], s[1]);
      end
      // Serial host write, then a read of the complement address
      do_reset(1'b0, 1'b1, 1'b0);
      ta = 11'($urandom);
      td = 8'($urandom);
      n0 = wr_cnt;
      host.stray();
      host.ser_access(1'b0, ta, td, q);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK("serial_writes", n0 + 1, wr_cnt)
      `CHK("serial_addr", ta, wr_addr)
      `CHK("serial_data", td, wr_data)
      n0 = rd_cnt;
      host.ser_access(1'b1, ~ta, td, q);
      `CHK("serial_reads", n0 + 1, rd_cnt)
      `CHK("serial_rdata", (~ta[7:0]) ^ 8'h5A, q)
      tally_and_finish();
   end
endmodule

// *** verilog/gch_gpio_bit.sv ***
`timescale 1ns/1ns
module gch_gpio_bit (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Register side
   input wire logic wr,
   input wire logic wdir,
   input wire logic wlevel,
   output logic dir,
   output logic level_rd,
   // Pin
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe
);
   import gch_pkg::*;

   logic lvl;
   logic pin_q;

   // Direction and level bits; 1 in dir means output
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dir <= GPIO_RST[GPIO_DIR_POS];
         lvl <= GPIO_RST[GPIO_LVL_POS];
      end else if (wr) begin
         dir <= wdir;   // see RQ5
         lvl <= wlevel;
      end
   end

   // Pin sample, so readback is a clean register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= pin_in;
      end
   end

   // Readback shows the pin when input, the stored level when output
   assign level_rd = dir ? lvl : pin_q;   // see RQ6
   assign pin_out = lvl;                  // see RQ7
   assign pin_oe = dir;                   // see RQ5

   a_gpio_in_level: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ6
      (nrst && !dir && !wr) |=> (level_rd == $past(pin_in)))
      else $error("gpio input level not reported");
   a_gpio_out_drive: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ7
      (wr && wdir) |=> (pin_oe && pin_out == $past(wlevel)))
      else $error("gpio output not driven to level");
endmodule

// *** verilog/gch_top.sv ***
// What this block does
// RQ1: Driver enable high lets line drivers run; low forces all drivers off.
// RQ2: Driver enable touches only the drivers; everything else keeps running.
// RQ3: Mode-select enable open takes mode from hardware pin; low takes per-channel bit.
// RQ4: Hardware mode pin low means E1, open means T1/J1; ignored when enable low.
// RQ5: Each GPIO pin is input or output by its own direction bit.
// RQ6: An input GPIO reports its sensed level in its level bit.
// RQ7: An output GPIO drives the level held in its level bit.
// RQ8: Low reset pulse resets everything; reset sequence ends within 2 us.
// RQ9: Interrupt output asserts while any unmasked source is pending.
// RQ10: Two-bit config field picks interrupt driver type and active level.
// RQ11: Host access needs chip select low; activity with it high is ignored.
// RQ12: Host makes a new chip select fall for each access, held till done.
// RQ13: Parallel/serial strap: ground gives serial host port, supply gives parallel.
// RQ14: Serial uses select, clock, data in and out; parallel uses the bus pins.
// RQ15: Style strap ground gives data strobe with read/write, open gives two strobes.
// RQ16: Multiplex strap ground gives plain bus, open latches address from latch strobe.
// RQ17: Serial input is sampled on each rising edge of the host shift clock.
// RQ18: Interrupt output goes inactive once no unmasked source remains pending.
`timescale 1ns/1ns
module gch_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Line control
   input wire logic line_drv_enable,
   input wire logic hw_line_mode_select_enable,
   input wire logic hw_line_mode_pin,
   input wire logic [gch_pkg::NCH-1:0][7:0] channel_config_reg,
   output logic [gch_pkg::NCH-1:0] line_drv_on,
   output logic [gch_pkg::NCH-1:0] chan_e1_mode,
   output logic dev_ready,
   // General purpose pins
   input wire logic gpio_wr,
   input wire logic [3:0] gpio_wdata,
   output logic [3:0] gpio_rdata,
   input wire logic [gch_pkg::NGPIO-1:0] gpio_in,
   output logic [gch_pkg::NGPIO-1:0] gpio_out,
   output logic [gch_pkg::NGPIO-1:0] gpio_oe,
   // Interrupt
   input wire logic [7:0] global_config_reg,
   input wire logic [gch_pkg::NSRC-1:0] int_pending,
   input wire logic [gch_pkg::NSRC-1:0] int_mask,
   output logic irq_out,
   output logic irq_oe,
   // Host pins
   input wire logic cs_n,
   input wire logic ps_strap,
   input wire logic parallel_bus_style_strap,
   input wire logic bus_multiplex_strap,
   input wire logic host_pin_strobe,
   input wire logic host_serial_in,
   input wire logic addr_latch_strobe,
   input wire logic [gch_pkg::AW-1:0] host_addr_pin,
   input wire logic [gch_pkg::DW-1:0] host_data_in,
   output logic [gch_pkg::DW-1:0] host_data_out,
   output logic host_data_oe,
   output logic host_ack,
   output logic host_serial_out,
   // Host mode
   output logic host_is_parallel,
   output logic host_is_ds_style,
   output logic host_is_muxed,
   // Internal register access
   output logic host_rd,
   output logic host_wr,
   output logic [gch_pkg::AW-1:0] host_addr,
   output logic [gch_pkg::DW-1:0] host_wdata,
   input wire logic [gch_pkg::DW-1:0] host_rdata
);
   import gch_pkg::*;

   localparam int RST_BOUND = RST_CYC;

   gch_rst_e rst_state;
   logic [RST_CW-1:0] rst_cnt;
   logic irq_act;
   logic [1:0] int_cfg;
   logic cs_q;
   logic strobe_q;
   logic ale_q;
   logic armed;
   logic done;
   logic rd_d;
   logic [AW-1:0] mux_addr;
   logic par_rd_req;
   logic par_wr_req;
   logic ser_rise;
   logic ser_fall;
   logic [SER_CW-1:0] ser_cnt;
   logic [23:0] ser_sh;
   logic ser_rw;
   logic [DW-1:0] ser_out_sh;

   // ----------------------------------------
   // Reset sequence
   // ----------------------------------------

   // Counted wait after release; line drivers, interrupt request and host accesses stay off until it ends
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_state <= GCH_RS_HOLD;
         rst_cnt <= '0;
      end else begin
         unique case (rst_state)
            GCH_RS_HOLD: begin
               rst_state <= GCH_RS_SEQ;
               rst_cnt <= '0;
            end
            GCH_RS_SEQ: begin
               if (rst_cnt == RST_LAST) begin
                  rst_state <= GCH_RS_RUN;   // see RQ8
               end
               rst_cnt <= rst_cnt + 1'b1;
            end
            GCH_RS_RUN: begin
               rst_state <= GCH_RS_RUN;
            end
            default: begin
               rst_state <= GCH_RS_HOLD;
            end
         endcase
      end
   end

   assign dev_ready = (rst_state == GCH_RS_RUN);

   // Straps are caught while the sequence runs, never under the reset
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         host_is_parallel <= 1'b0;
         host_is_ds_style <= 1'b0;
         host_is_muxed <= 1'b0;
      end else if (rst_state == GCH_RS_SEQ) begin
         host_is_parallel <= ps_strap;                      // see RQ13
         host_is_ds_style <= ps_strap & ~parallel_bus_style_strap; // see RQ15
         host_is_muxed <= ps_strap & bus_multiplex_strap;   // see RQ16
      end
   end

   a_rst_finish_time: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ8
      nrst && !dev_ready |-> ##[1:RST_BOUND] dev_ready)   // Release edge not counted
      else $error("reset sequence longer than 2 us");

   // ----------------------------------------
   // Line drivers and line mode
   // ----------------------------------------

   // Pin override beats the per-channel enable; mode ignores the pin
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         line_drv_on <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            line_drv_on[i] <= dev_ready & line_drv_enable
               & channel_config_reg[i][CH_DRV_POS];   // see RQ1
         end
      end
   end

   // Mode follows pins or per-channel bits regardless of drivers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         chan_e1_mode <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            chan_e1_mode[i] <= hw_line_mode_select_enable ? ~hw_line_mode_pin // see RQ4
               : channel_config_reg[i][CH_MODE_POS];                          // see RQ3
         end
      end
   end

   a_drv_forced_off: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ1
      !line_drv_enable |=> (line_drv_on == '0))
      else $error("driver on while global enable low");
   a_drv_follow_cfg: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ1
      (dev_ready && line_drv_enable && channel_config_reg[0][CH_DRV_POS]) |=> line_drv_on[0])
      else $error("driver not enabled");
   a_mode_hw_pin: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ4
      hw_line_mode_select_enable |=> (chan_e1_mode == {NCH{$past(~hw_line_mode_pin)}}))
      else $error("hardware mode pin not applied");
   a_mode_per_chan: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ3
      !hw_line_mode_select_enable |=> (chan_e1_mode[NCH-1] == $past(
         channel_config_reg[NCH-1][CH_MODE_POS])))
      else $error("per-channel mode bit not applied");
   a_mode_oe_free: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ2
      (!line_drv_enable && hw_line_mode_select_enable) |=> (chan_e1_mode[0] == $past(~hw_line_mode_pin)))
      else $error("mode stalled by driver enable");

   // ----------------------------------------
   // General purpose pins
   // ----------------------------------------

   for (genvar g = 0; g < NGPIO; g++) begin : gen_gpio
      gch_gpio_bit u_bit (
         .core_clk(core_clk),
         .nrst(nrst),
         .wr(gpio_wr),
         .wdir(gpio_wdata[GPIO_DIR_POS + g]),
         .wlevel(gpio_wdata[GPIO_LVL_POS + g]),
         .dir(gpio_rdata[GPIO_DIR_POS + g]),   // see RQ5
         .level_rd(gpio_rdata[GPIO_LVL_POS + g]),
         .pin_in(gpio_in[g]),
         .pin_out(gpio_out[g]),
         .pin_oe(gpio_oe[g])
      );
   end

   // ----------------------------------------
   // Interrupt pin
   // ----------------------------------------

   // One shared request for all unmasked sources
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_act <= 1'b0;
      end else begin
         irq_act <= dev_ready & (|(int_pending & ~int_mask));   // see RQ9
      end
   end

   assign int_cfg = global_config_reg[GCFG_INT_POS +: 2];
   // Open drain only drives when active, so the pull sets the idle level
   assign irq_oe = int_cfg[INT_PP_BIT] | irq_act;               // see RQ10
   assign irq_out = irq_act ? int_cfg[INT_LVL_BIT] : ~int_cfg[INT_LVL_BIT]; // see RQ18

   a_irq_raise: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ9
      (dev_ready && |(int_pending & ~int_mask)) |=> (irq_oe && irq_out == int_cfg[INT_LVL_BIT]))
      else $error("unmasked interrupt not signalled");
   a_irq_release: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ18
      !(|(int_pending & ~int_mask)) |=> (irq_out != int_cfg[INT_LVL_BIT]
         && irq_oe == int_cfg[INT_PP_BIT]))
      else $error("interrupt stays active");

   // ----------------------------------------
   // Host pin decode
   // ----------------------------------------

   assign ser_rise = host_pin_strobe & ~strobe_q;   // see RQ17
   assign ser_fall = ~host_pin_strobe & strobe_q;
   // Strobe pin is data strobe or read strobe; input pin is read/write or write strobe
   assign par_rd_req = host_is_ds_style ? (~host_pin_strobe & host_serial_in)
      : ~host_pin_strobe;                                       // see RQ15
   assign par_wr_req = host_is_ds_style ? (~host_pin_strobe & ~host_serial_in)
      : ~host_serial_in;

   // Pin history for edge detection
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cs_q <= 1'b1;
         strobe_q <= 1'b1;   // Strobes idle high, so no false edge after reset
         ale_q <= 1'b0;
      end else begin
         cs_q <= cs_n;
         strobe_q <= host_pin_strobe;
         ale_q <= addr_latch_strobe;
      end
   end

   // Multiplexed address is taken on the latch strobe falling edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mux_addr <= '0;
      end else if (ale_q && !addr_latch_strobe) begin
         mux_addr <= {host_addr_pin[AW-1:DW], host_data_in};   // see RQ16
      end
   end

   // Serial shifter; frame is read flag, 4 spare, 11 address, 8 data
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ser_cnt <= '0;
         ser_sh <= '0;
         ser_rw <= 1'b0;
      end else if (cs_n || host_is_parallel) begin
         ser_cnt <= '0;                                  // see RQ11
      end else if (ser_rise && ser_cnt != SER_DAT_LAST + 1'b1) begin
         ser_sh <= {ser_sh[22:0], host_serial_in};       // see RQ17
         ser_cnt <= ser_cnt + 1'b1;
         if (ser_cnt == SER_HDR_LAST) begin
            ser_rw <= ser_sh[SER_RW_POS - 1];
         end
      end
   end

   // Read data leaves on falling shift clock edges, most significant first;
   // the first fall only presents the top bit, so a slow clock loses nothing
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ser_out_sh <= '0;
      end else if (rd_d && !host_is_parallel) begin
         ser_out_sh <= host_rdata;
      end else if (ser_fall && !cs_n && ser_cnt > SER_HDR_LAST + 1'b1) begin
         ser_out_sh <= {ser_out_sh[DW-2:0], 1'b0};
      end
   end

   assign host_serial_out = ser_out_sh[DW-1];   // see RQ14

   // ----------------------------------------
   // Access issue
   // ----------------------------------------

   // One access per chip select fall; a held select cannot repeat it
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         armed <= 1'b0;
         done <= 1'b0;
         host_rd <= 1'b0;
         host_wr <= 1'b0;
         host_addr <= '0;
         host_wdata <= '0;
      end else begin
         host_rd <= 1'b0;
         host_wr <= 1'b0;
         if (cs_n || !dev_ready) begin
            armed <= 1'b0;                              // see RQ11
            done <= 1'b0;
         end else if (cs_q) begin
            armed <= 1'b1;                              // see RQ12
         end else if (armed && host_is_parallel && (par_rd_req || par_wr_req)) begin
            armed <= 1'b0;
            done <= 1'b1;
            host_rd <= par_rd_req;                       // see RQ14
            host_wr <= par_wr_req & ~par_rd_req;
            host_addr <= host_is_muxed ? mux_addr : host_addr_pin;
            host_wdata <= host_data_in;
         end else if (armed && !host_is_parallel && ser_rise) begin
            if (ser_cnt == SER_HDR_LAST && ser_sh[SER_RW_POS - 1]) begin
               armed <= 1'b0;
               done <= 1'b1;
               host_rd <= 1'b1;
               host_addr <= {ser_sh[AW-2:0], host_serial_in};
            end else if (ser_cnt == SER_HDR_LAST) begin
               host_addr <= {ser_sh[AW-2:0], host_serial_in};
            end else if (ser_cnt == SER_DAT_LAST && !ser_rw) begin
               armed <= 1'b0;
               done <= 1'b1;
               host_wr <= 1'b1;
               host_wdata <= {ser_sh[DW-2:0], host_serial_in};
            end
         end
      end
   end

   // Read data register and acknowledge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rd_d <= 1'b0;
         host_data_out <= '0;
         host_ack <= 1'b0;
      end else begin
         rd_d <= host_rd;
         if (rd_d) begin
            host_data_out <= host_rdata;
         end
         host_ack <= done & ~rd_d & ~host_rd & ~cs_n;
      end
   end

   assign host_data_oe = host_is_parallel & ~cs_n & done & par_rd_req;

   a_cs_ignore: assert property (@(posedge core_clk) disable iff (!nrst) // see RQ11
      cs_n |=> (!host_rd && !host_wr && !host_ack))
      else $error("access taken with chip select high");
endmodule
